// file: tb/tmcr_host.sv
// Host model that drives the register port of the configuration bank
// Assumes the bank answers a read in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tmcr_host
  import tmcr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output var tmcr_pkg::tmcr_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid
);
  initial bus_req = '0;
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
    v = bus_rvalid;
  endtask
endmodule
`default_nettype wire

// file: tb/tmcr_regs_chk.sv
// Checker for the main configuration register bank
// Bound to tmcr_regs, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tmcr_regs_chk
  import tmcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire tmcr_pkg::tmcr_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  // Decoded settings
  input wire tmcr_pkg::tmcr_cfg_t cfg,
  input wire tmcr_pkg::tmcr_group_t last_group,
  input wire logic packet_mode,
  input wire logic slow_ramp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic w0 = bus_req.wr && bus_req.addr == 5'h00;
  wire logic w1 = bus_req.wr && bus_req.addr == 5'h01;
  chk_read_answer: assert property (1 |=> bus_rvalid == $past(bus_req.rd))
    else $error("read valid off");
  chk_unmapped_read: assert property (bus_req.rd && bus_req.addr > 5'h05
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_state_hold: assert property (w0 && bus_req.wdata[7:5] > 3'h4
    |=> $stable(cfg.op_state)) else $error("bad state code taken");
  chk_quarter_write: assert property (w0
    |=> cfg.quarter == $past(bus_req.wdata[1:0])) else $error("quarter");
  chk_packet_mode: assert property (w1
    |=> packet_mode == $past(bus_req.wdata[7])) else $error("packet");
  chk_thresh_hold: assert property (w1 && bus_req.wdata[3:2] == 2'h3
    |=> $stable(cfg.keying_threshold_method)) else $error("thresh");
  chk_no_write: assert property (!bus_req.wr |=> $stable(cfg))
    else $error("settings changed without write");
  chk_coeff_c: assert property (bus_req.wr && bus_req.addr == 5'h03
    |=> cfg.rate_coeff_c == $past(bus_req.wdata)) else $error("coeff c");
endmodule
bind tmcr_regs tmcr_regs_chk i_chk (.mclk, .sys_rst, .bus_req, .bus_rdata,
  .bus_rvalid, .cfg, .last_group, .packet_mode, .slow_ramp);
`default_nettype wire

// file: tb/tmcr_regs_tb.sv
// Testbench for the main configuration register bank
// Assumes tmcr_host drives the register port
`timescale 1ns/1ps
`default_nettype none
module tmcr_regs_tb;
  import tmcr_pkg::*;
  logic mclk, sys_rst, bus_rvalid, packet_mode, slow_ramp, rv;
  logic [7:0] bus_rdata, rd_val;
  tmcr_bus_req_t bus_req;
  tmcr_cfg_t cfg;
  tmcr_group_t last_group;
  int err_count = 0;
  int tests_run = 0;
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  tmcr_regs i_dut (.mclk, .sys_rst, .bus_req, .bus_rdata, .bus_rvalid,
    .cfg, .last_group, .packet_mode, .slow_ramp);
  tmcr_host i_host (.mclk, .bus_req, .bus_rdata, .bus_rvalid);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rd_chk(logic [4:0] a, logic [7:0] exp);
    i_host.rd(a, rd_val, rv);
    check("read", {rv, rd_val}, {1'b1, exp});
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_reset();
    check("group", last_group, TMCR_GRP_NONE);
    rd_chk(5'h00, 8'h30);
    rd_chk(5'h01, 8'h24);
    rd_chk(5'h02, 8'h03);
    rd_chk(5'h03, 8'h07);
    rd_chk(5'h04, 8'h0f);
    rd_chk(5'h05, 8'hc6);
    check("slow", {packet_mode, slow_ramp}, 2'b01);
  endtask
  task automatic t_main();
    logic [7:0] b;
    for (int s = 0; s < 5; s++)
    begin
      b = {s[2:0], 3'(s + 1), s[1:0]};
      i_host.wr(5'h00, b);
      rd_chk(5'h00, b);
    end
    i_host.wr(5'h00, 8'hfb);
    rd_chk(5'h00, 8'h97);
    for (int m = 0; m < 4; m++)
    begin
      b = {4{m[1:0]}};
      i_host.wr(5'h01, b);
      rd_chk(5'h01, (m == 3) ? 8'hfb : b);
      check("pkt", packet_mode, m[1]);
    end
  endtask
  task automatic t_bytes();
    i_host.wr(5'h03, 8'hff);
    i_host.wr(5'h04, 8'h0f);
    i_host.wr(5'h02, 8'h00);
    i_host.wr(5'h05, 8'h7e);
    rd_chk(5'h03, 8'hff);
    rd_chk(5'h04, 8'h0f);
    rd_chk(5'h02, 8'h00);
    rd_chk(5'h05, 8'h7e);
    check("ramp", {cfg.amplifier_ramp_time, slow_ramp}, 3'b011);
  endtask
  task automatic t_groups();
    logic [4:0] adr [12] = '{11, 12, 15, 16, 21, 22, 25, 26, 27, 28, 30, 31};
    tmcr_group_t grp [12] = '{TMCR_GRP_MAIN, TMCR_GRP_IRQ, TMCR_GRP_IRQ,
      TMCR_GRP_RX, TMCR_GRP_RX, TMCR_GRP_SYNC, TMCR_GRP_SYNC, TMCR_GRP_TX,
      TMCR_GRP_OSC, TMCR_GRP_PKT, TMCR_GRP_PKT, TMCR_GRP_NONE};
    for (int i = 0; i < 12; i++)
    begin
      i_host.wr(adr[i], 8'h5a);
      rd_chk(adr[i], 8'h00);
      check("group", last_group, grp[i]);
    end
    rd_chk(5'h03, 8'hff);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    do_reset();
    t_reset();
    t_main();
    t_bytes();
    t_groups();
    do_reset();
    t_reset();
    conclude();
  end
  initial
  begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire

// file: verilog/tmcr_pkg.sv
// Package for the transceiver main configuration register bank
// Assumes a byte-wide register port on a single clock
package tmcr_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] TMCR_OFF_STATE_BAND = 5'h00;
  localparam logic [4:0] TMCR_OFF_DATA_MOD = 5'h01;
  localparam logic [4:0] TMCR_OFF_DEV_DIV = 5'h02;
  localparam logic [4:0] TMCR_OFF_RATE_C = 5'h03;
  localparam logic [4:0] TMCR_OFF_RATE_D = 5'h04;
  localparam logic [4:0] TMCR_OFF_RAMP = 5'h05;

  // ------------------------------------------------------------
  // Group boundaries
  // ------------------------------------------------------------
  localparam logic [4:0] TMCR_MAIN_LAST = 5'h0b;
  localparam logic [4:0] TMCR_IRQ_LAST = 5'h0f;
  localparam logic [4:0] TMCR_RX_LAST = 5'h15;
  localparam logic [4:0] TMCR_SYNC_LAST = 5'h19;
  localparam logic [4:0] TMCR_TX_ADDR = 5'h1a;
  localparam logic [4:0] TMCR_OSC_ADDR = 5'h1b;
  localparam logic [4:0] TMCR_PKT_LAST = 5'h1e;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [2:0] TMCR_RST_STATE = 3'h1;
  localparam logic [2:0] TMCR_RST_BAND = 3'h4;
  localparam logic [1:0] TMCR_RST_QUARTER = 2'h0;
  localparam logic [1:0] TMCR_RST_DATA_MODE = 2'h0;
  localparam logic [1:0] TMCR_RST_MOD = 2'h2;
  localparam logic [1:0] TMCR_RST_THRESH = 2'h1;
  localparam logic [1:0] TMCR_RST_IF_GAIN = 2'h0;
  localparam logic [7:0] TMCR_RST_DEV = 8'h03;
  localparam logic [7:0] TMCR_RST_RATE_C = 8'h07;
  localparam logic [7:0] TMCR_RST_RATE_D = 8'h0f;
  localparam logic [1:0] TMCR_RST_RAMP = 2'h3;
  localparam logic [5:0] TMCR_RST_RAMP_LOW = 6'h06;

  // ------------------------------------------------------------
  // Codes and limits
  // ------------------------------------------------------------
  localparam logic [2:0] TMCR_STATE_MAX = 3'h4;
  localparam logic [2:0] TMCR_BAND_MAX = 3'h5;
  localparam logic [1:0] TMCR_THRESH_RSVD = 2'h3;
  localparam logic [1:0] TMCR_RAMP_FAST = 2'h0;
  localparam logic [7:0] TMCR_RATE_D_MIN = 8'h0f;

  // Operating states
  typedef enum logic [2:0] {
    TMCR_SLEEP = 3'h0,
    TMCR_STANDBY = 3'h1,
    TMCR_SYNTH_ONLY_STATE = 3'h2,
    TMCR_RECEIVE = 3'h3,
    TMCR_TRANSMIT = 3'h4
  } tmcr_op_state_t;

  // Parameter groups
  typedef enum logic [2:0] {
    TMCR_GRP_MAIN = 3'h0,
    TMCR_GRP_IRQ = 3'h1,
    TMCR_GRP_RX = 3'h3,
    TMCR_GRP_SYNC = 3'h2,
    TMCR_GRP_TX = 3'h6,
    TMCR_GRP_OSC = 3'h7,
    TMCR_GRP_PKT = 3'h5,
    TMCR_GRP_NONE = 3'h4
  } tmcr_group_t;

  // Register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmcr_bus_req_t;

  // Decoded settings
  typedef struct packed {
    logic [2:0] op_state;
    logic [2:0] band;
    logic [1:0] quarter;
    logic [1:0] data_mode;
    logic [1:0] modulation_select;
    logic [1:0] keying_threshold_method;
    logic [1:0] if_gain;
    logic [7:0] deviation;
    logic [7:0] rate_coeff_c;
    logic [7:0] rate_coeff_d;
    logic [1:0] amplifier_ramp_time;
    logic [5:0] ramp_low;
  } tmcr_cfg_t;

  // Whole module state
  typedef struct packed {
    tmcr_cfg_t cfg;
    logic [7:0] rdata;
    logic rvalid;
    tmcr_group_t group;
    logic packet_mode;
    logic slow_ramp;
  } tmcr_state_t;

endpackage

// file: verilog/tmcr_regs.sv
// Main configuration register bank of a sub-GHz FSK/OOK transceiver
// Assumes a host register port on mclk with read data one cycle later

`timescale 1ns/1ps
`default_nettype none

module tmcr_regs
  import tmcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire tmcr_pkg::tmcr_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // Decoded settings
  output tmcr_pkg::tmcr_cfg_t cfg,
  output tmcr_pkg::tmcr_group_t last_group,
  output logic packet_mode,
  output logic slow_ramp
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic tmcr_group_t group_of(input logic [4:0] a);
    tmcr_group_t g;
    g = TMCR_GRP_NONE;
    if (a <= TMCR_MAIN_LAST)
      g = TMCR_GRP_MAIN;
    else if (a <= TMCR_IRQ_LAST)
      g = TMCR_GRP_IRQ;
    else if (a <= TMCR_RX_LAST)
      g = TMCR_GRP_RX;
    else if (a <= TMCR_SYNC_LAST)
      g = TMCR_GRP_SYNC;
    else if (a == TMCR_TX_ADDR)
      g = TMCR_GRP_TX;
    else if (a == TMCR_OSC_ADDR)
      g = TMCR_GRP_OSC;
    else if (a <= TMCR_PKT_LAST)
      g = TMCR_GRP_PKT;
    return g;
  endfunction

  tmcr_state_t st_reg;
  tmcr_state_t st_next;
  tmcr_group_t acc_group;
  logic acc;

  assign acc = bus_req.wr | bus_req.rd;
  assign acc_group = group_of(bus_req.addr);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.rvalid = bus_req.rd;
    st_next.rdata = 8'h00;
    if (acc)
      st_next.group = acc_group;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        TMCR_OFF_STATE_BAND:
        begin
          if (bus_req.wdata[7:5] <= TMCR_STATE_MAX)
            st_next.cfg.op_state = bus_req.wdata[7:5];
          if (bus_req.wdata[4:2] <= TMCR_BAND_MAX)
            st_next.cfg.band = bus_req.wdata[4:2];
          st_next.cfg.quarter = bus_req.wdata[1:0];
        end
        TMCR_OFF_DATA_MOD:
        begin
          st_next.cfg.data_mode = bus_req.wdata[7:6];
          st_next.cfg.modulation_select = bus_req.wdata[5:4];
          if (bus_req.wdata[3:2] != TMCR_THRESH_RSVD)
            st_next.cfg.keying_threshold_method = bus_req.wdata[3:2];
          st_next.cfg.if_gain = bus_req.wdata[1:0];
        end
        TMCR_OFF_DEV_DIV:
          st_next.cfg.deviation = bus_req.wdata;
        TMCR_OFF_RATE_C:
          st_next.cfg.rate_coeff_c = bus_req.wdata;
        TMCR_OFF_RATE_D:
          st_next.cfg.rate_coeff_d = bus_req.wdata;
        TMCR_OFF_RAMP:
        begin
          st_next.cfg.amplifier_ramp_time = bus_req.wdata[7:6];
          st_next.cfg.ramp_low = bus_req.wdata[5:0];
        end
        default:
          st_next.cfg = st_reg.cfg;
      endcase
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        TMCR_OFF_STATE_BAND:
          st_next.rdata = {st_reg.cfg.op_state, st_reg.cfg.band,
                           st_reg.cfg.quarter};
        TMCR_OFF_DATA_MOD:
          st_next.rdata = {st_reg.cfg.data_mode,
                           st_reg.cfg.modulation_select,
                           st_reg.cfg.keying_threshold_method,
                           st_reg.cfg.if_gain};
        TMCR_OFF_DEV_DIV:
          st_next.rdata = st_reg.cfg.deviation;
        TMCR_OFF_RATE_C:
          st_next.rdata = st_reg.cfg.rate_coeff_c;
        TMCR_OFF_RATE_D:
          st_next.rdata = st_reg.cfg.rate_coeff_d;
        TMCR_OFF_RAMP:
          st_next.rdata = {st_reg.cfg.amplifier_ramp_time,
                           st_reg.cfg.ramp_low};
        default:
          st_next.rdata = 8'h00;
      endcase
    end
    st_next.packet_mode = st_next.cfg.data_mode[1];
    st_next.slow_ramp = (st_next.cfg.amplifier_ramp_time != TMCR_RAMP_FAST);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg.cfg.op_state <= TMCR_RST_STATE;
      st_reg.cfg.band <= TMCR_RST_BAND;
      st_reg.cfg.quarter <= TMCR_RST_QUARTER;
      st_reg.cfg.data_mode <= TMCR_RST_DATA_MODE;
      st_reg.cfg.modulation_select <= TMCR_RST_MOD;
      st_reg.cfg.keying_threshold_method <= TMCR_RST_THRESH;
      st_reg.cfg.if_gain <= TMCR_RST_IF_GAIN;
      st_reg.cfg.deviation <= TMCR_RST_DEV;
      st_reg.cfg.rate_coeff_c <= TMCR_RST_RATE_C;
      st_reg.cfg.rate_coeff_d <= TMCR_RST_RATE_D;
      st_reg.cfg.amplifier_ramp_time <= TMCR_RST_RAMP;
      st_reg.cfg.ramp_low <= TMCR_RST_RAMP_LOW;
      st_reg.rdata <= 8'h00;
      st_reg.rvalid <= 1'b0;
      st_reg.group <= TMCR_GRP_NONE;
      st_reg.packet_mode <= 1'b0;
      st_reg.slow_ramp <= (TMCR_RST_RAMP != TMCR_RAMP_FAST);
    end
    else
      st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus_rdata = st_reg.rdata;
  assign bus_rvalid = st_reg.rvalid;
  assign cfg = st_reg.cfg;
  assign last_group = st_reg.group;
  assign packet_mode = st_reg.packet_mode;
  assign slow_ramp = st_reg.slow_ramp;

endmodule

`default_nettype wire
